// >>> shared/gpio_ef_defines.svh
// Offsets, field positions and reset values for the two GPIO ports.
// Assumes the register port presents the low eight bits of the byte address.
`ifndef GPIO_EF_DEFINES_SVH
`define GPIO_EF_DEFINES_SVH

// Register offsets; each data latch answers at two aliased addresses.
`define OFS_FIRST_LATCH_A      8'h11
`define OFS_FIRST_LATCH_B      8'h13
`define OFS_FIRST_DIRECTION    8'h15
`define OFS_FIRST_FUNC_SELECT  8'h17
`define OFS_SECOND_LATCH_A     8'h19
`define OFS_SECOND_LATCH_B     8'h1B
`define OFS_SECOND_DIRECTION   8'h1D
`define OFS_SECOND_FUNC_SELECT 8'h1F

// Reset values.
`define RST_LATCH              8'h00
`define RST_DIRECTION          8'h00
`define RST_FUNC_ALL_DEDICATED 8'hFF
`define RST_FUNC_ALL_IO        8'h00
`define RD_IDLE                8'h00

// First port bit positions of the dedicated functions.
`define BIT_SIZE_HIGH          7
`define BIT_SIZE_LOW           6
`define BIT_ADDR_STROBE        5
`define BIT_DATA_STROBE        4
`define BIT_UNBONDED           3
`define BIT_AUTOVECTOR         2
`define BIT_ACK_ONE            1
`define BIT_ACK_ZERO           0

// Second port bit positions.
`define BIT_CLOCK_MODE         0

`endif

// >>> shared/gpio_ef_pkg.sv
// Types shared by the GPIO port block and its bench.
// Assumes gpio_ef_defines.svh supplies the numeric constants.
package gpio_ef_pkg;

  // Software-visible state of one 8-bit port.
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] direction;
    logic [7:0] func_select;
  } port_regs_t;

  // Bus-control outputs that the first port carries in its dedicated role.
  typedef struct packed {
    logic [1:0] transfer_size;
    logic       addr_strobe_n;
    logic       data_strobe_n;
  } bus_ctrl_t;

  // Bus-control inputs that the first port delivers in its dedicated role.
  typedef struct packed {
    logic       autovector_request_n;
    logic       transfer_ack_one_n;
    logic       transfer_ack_zero_n;
  } bus_ack_t;

endpackage

// >>> logic/gpio_ports_ef.sv
// Two 8-bit general-purpose ports of the system integration unit.
// Assumes pins are synchronous to clk and a register port with one-cycle read data.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "gpio_ef_defines.svh"

// What this block does
// - First port writes land in its latch; output I/O pins drive latched bits.
// - First port reads give pin level for discrete inputs, latch otherwise.
// - First port latch is one register decoded at two addresses, always accessible.
// - Second port writes land in its latch; output I/O pins drive latched bits.
// - Second port reads pin for discrete inputs, latch otherwise; two aliased addresses.
// - Direction one makes an output, zero an input; both reset to zero.
// - First port direction register is readable and writable at any time.
// - First port function bit one gives bus control, zero gives plain I/O.
// - First port bits: 7,6 size, 5 address strobe, 4 data strobe, 2 autovector, 1,0 acks.
// - First port function register resets to all ones or zeros from bus bit eight.
// - First port bit 3 has no pin; function reads one, direction is plain storage, latch reads pin while stored function and direction bit 3 are zero.
// - Second port function bit one gives interrupt input on bits 7..1 (bit 0 pin is left undriven), zero gives plain I/O.
// - Second port bits 7..1 are interrupt levels 7..1, bit 0 clock-mode select.
// - Clock-mode select pin matters only while reset is applied.
// - Second port function register resets to all ones or zeros from bus bit nine.
module gpio_ports_ef
  import gpio_ef_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Register port.
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Configuration straps sampled while reset is held.
  input  wire logic       boot_bus_bit_eight,
  input  wire logic       boot_bus_bit_nine,
  // First port pins.
  input  wire logic [7:0] first_pin_in,
  output logic      [7:0] first_pin_out,
  output logic      [7:0] first_pin_oe,
  // Second port pins.
  input  wire logic [7:0] second_pin_in,
  output logic      [7:0] second_pin_out,
  output logic      [7:0] second_pin_oe,
  // Bus controller side of the first port's dedicated functions.
  input  wire bus_ctrl_t  bus_ctrl,
  output bus_ack_t        bus_ack,
  // Interrupt controller side of the second port's dedicated functions.
  output logic      [7:1] irq_level_n,
  output logic            clock_source_select_pin
);

  port_regs_t first_reg;
  port_regs_t second_reg;
  logic [7:0] rdata_reg;
  logic [7:0] first_out_reg;
  logic [7:0] first_oe_reg;
  logic [7:0] second_out_reg;
  logic [7:0] second_oe_reg;
  bus_ack_t   ack_reg;
  logic [7:1] irq_reg;
  logic       clock_mode_reg;

  // Address decode; the two aliases of each latch hit the same storage.
  wire logic hit_first_latch  = (reg_addr == `OFS_FIRST_LATCH_A)
                              || (reg_addr == `OFS_FIRST_LATCH_B);
  wire logic hit_first_dir    = (reg_addr == `OFS_FIRST_DIRECTION);
  wire logic hit_first_func   = (reg_addr == `OFS_FIRST_FUNC_SELECT);
  wire logic hit_second_latch = (reg_addr == `OFS_SECOND_LATCH_A)
                              || (reg_addr == `OFS_SECOND_LATCH_B);
  wire logic hit_second_dir   = (reg_addr == `OFS_SECOND_DIRECTION);
  wire logic hit_second_func  = (reg_addr == `OFS_SECOND_FUNC_SELECT);

  // Unbonded bit of the first port: its function bit always reads one and is forced to one on writes.
  wire logic [7:0] unbonded_mask = 8'h01 << `BIT_UNBONDED;

  // A pin reads back live only when it is plain I/O and set as an input.
  wire logic [7:0] first_is_input  = ~first_reg.func_select & ~first_reg.direction;
  wire logic [7:0] second_is_input = ~second_reg.func_select & ~second_reg.direction;
  wire logic [7:0] first_read  = (first_is_input & first_pin_in)
                               | (~first_is_input & first_reg.latch);
  wire logic [7:0] second_read = (second_is_input & second_pin_in)
                               | (~second_is_input & second_reg.latch);

  // Read multiplexer; unmapped addresses answer zero.
  wire logic [7:0] rd_mux =
      hit_first_latch  ? first_read :
      hit_first_dir    ? first_reg.direction :
      hit_first_func   ? (first_reg.func_select | unbonded_mask) :
      hit_second_latch ? second_read :
      hit_second_dir   ? second_reg.direction :
      hit_second_func  ? second_reg.func_select :
      `RD_IDLE;

  // Dedicated drive for the first port's output functions.
  wire logic [7:0] first_ded_out = {bus_ctrl.transfer_size, bus_ctrl.addr_strobe_n,
                                    bus_ctrl.data_strobe_n, 4'h0};
  wire logic [7:0] first_ded_oe  = (8'h01 << `BIT_SIZE_HIGH) | (8'h01 << `BIT_SIZE_LOW)
                                 | (8'h01 << `BIT_ADDR_STROBE) | (8'h01 << `BIT_DATA_STROBE);

  // Pin drive: dedicated pins ignore latch and direction; I/O pins follow them.
  wire logic [7:0] first_out_next = (first_reg.func_select & first_ded_out)
                                  | (~first_reg.func_select & first_reg.latch);
  wire logic [7:0] first_oe_next  = ((first_reg.func_select & first_ded_oe)
                                  | (~first_reg.func_select & first_reg.direction))
                                  & ~unbonded_mask;
  wire logic [7:0] second_out_next = ~second_reg.func_select & second_reg.latch;
  wire logic [7:0] second_oe_next  = ~second_reg.func_select & second_reg.direction;

  // Dedicated inputs pass through only when their pin is assigned; else inactive high.
  wire bus_ack_t ack_next = '{
    autovector_request_n: ~first_reg.func_select[`BIT_AUTOVECTOR]
                        | first_pin_in[`BIT_AUTOVECTOR],
    transfer_ack_one_n:   ~first_reg.func_select[`BIT_ACK_ONE]
                        | first_pin_in[`BIT_ACK_ONE],
    transfer_ack_zero_n:  ~first_reg.func_select[`BIT_ACK_ZERO]
                        | first_pin_in[`BIT_ACK_ZERO]};
  wire logic [7:1] irq_next = ~second_reg.func_select[7:1] | second_pin_in[7:1];

  // First port registers; the function register reloads from its strap during reset.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      first_reg.latch       <= `RST_LATCH;
      first_reg.direction   <= `RST_DIRECTION;
      first_reg.func_select <= boot_bus_bit_eight ? `RST_FUNC_ALL_DEDICATED
                                                  : `RST_FUNC_ALL_IO;
    end
    else if (reg_wr)
    begin
      if (hit_first_latch)
        first_reg.latch <= reg_wdata;
      if (hit_first_dir)
        first_reg.direction <= reg_wdata;
      if (hit_first_func)
        first_reg.func_select <= reg_wdata | unbonded_mask;
    end
  end

  // Second port registers, same pattern with the other strap.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      second_reg.latch       <= `RST_LATCH;
      second_reg.direction   <= `RST_DIRECTION;
      second_reg.func_select <= boot_bus_bit_nine ? `RST_FUNC_ALL_DEDICATED
                                                  : `RST_FUNC_ALL_IO;
    end
    else if (reg_wr)
    begin
      if (hit_second_latch)
        second_reg.latch <= reg_wdata;
      if (hit_second_dir)
        second_reg.direction <= reg_wdata;
      if (hit_second_func)
        second_reg.func_select <= reg_wdata;
    end
  end

  // Read data stands for exactly the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_reg <= `RD_IDLE;
    else
      rdata_reg <= reg_rd ? rd_mux : `RD_IDLE;
  end

  // Registered pin drivers; all pins float while reset is held.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      first_out_reg  <= 8'h00;
      first_oe_reg   <= 8'h00;
      second_out_reg <= 8'h00;
      second_oe_reg  <= 8'h00;
      ack_reg        <= '1;
      irq_reg        <= '1;
    end
    else
    begin
      first_out_reg  <= first_out_next;
      first_oe_reg   <= first_oe_next;
      second_out_reg <= second_out_next;
      second_oe_reg  <= second_oe_next;
      ack_reg        <= ack_next;
      irq_reg        <= irq_next;
    end
  end

  // Clock-mode pin is tracked only during reset and frozen afterwards, so later
  // toggling of that pin cannot disturb the clock source choice.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      clock_mode_reg <= second_pin_in[`BIT_CLOCK_MODE];
  end

  assign reg_rdata               = rdata_reg;
  assign first_pin_out           = first_out_reg;
  assign first_pin_oe            = first_oe_reg;
  assign second_pin_out          = second_out_reg;
  assign second_pin_oe           = second_oe_reg;
  assign bus_ack                 = ack_reg;
  assign irq_level_n             = irq_reg;
  assign clock_source_select_pin = clock_mode_reg;

endmodule

// >>> verification/gpio_ports_ef_props.sv
// Checker for the GPIO port block; it sees only the block's ports.
// Assumes the register offsets of gpio_ef_defines.svh and one clock domain.
`timescale 1ns/1ns
`include "gpio_ef_defines.svh"
module gpio_ports_ef_props
  import gpio_ef_pkg::*;
(
  // Clock, reset and register port.
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins and dedicated functions.
  input wire logic [7:0] first_pin_in,
  input wire logic [7:0] first_pin_oe,
  input wire logic [7:0] second_pin_in,
  input wire logic [7:0] second_pin_oe,
  input wire bus_ack_t   bus_ack,
  input wire logic [7:1] irq_level_n,
  input wire logic       clock_source_select_pin
);
  // One domain, so clock and reset are given once for every check.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_dir_rw; reg_wr && reg_addr == `OFS_FIRST_DIRECTION ##1
    reg_rd && reg_addr == `OFS_FIRST_DIRECTION |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_dir_rw: assert property (p_dir_rw) else $error("direction read differs");
  property p_oe_reset; !$past(rst_n) |-> first_pin_oe == 8'h00 && second_pin_oe == 8'h00;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("pin driven out of reset");
  property p_clk_frozen; $past(rst_n) |-> $stable(clock_source_select_pin); endproperty
  a_clk_frozen: assert property (p_clk_frozen) else $error("clock mode moved");
  property p_clk_sample; !$past(rst_n) |-> clock_source_select_pin == $past(second_pin_in[0]);
  endproperty
  a_clk_sample: assert property (p_clk_sample) else $error("clock mode not sampled");
  property p_irq_follow; (~irq_level_n & $past(second_pin_in[7:1])) == 7'h00; endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("request without low pin");
  property p_irq_nodrive; (second_pin_oe[7:1] & ~irq_level_n) == 7'h00; endproperty
  a_irq_nodrive: assert property (p_irq_nodrive) else $error("request on output");
  property p_ack_nodrive; (first_pin_oe[2:0] & ~bus_ack) == 3'h0; endproperty
  a_ack_nodrive: assert property (p_ack_nodrive) else $error("ack on output");
  property p_ack_follow; (~bus_ack & $past(first_pin_in[2:0])) == 3'h0; endproperty
  a_ack_follow: assert property (p_ack_follow) else $error("ack without low pin");
endmodule

bind gpio_ports_ef gpio_ports_ef_props props_i (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .first_pin_in, .first_pin_oe, .second_pin_in, .second_pin_oe,
  .bus_ack, .irq_level_n, .clock_source_select_pin);

// >>> verification/pin_board_model.sv
// Board logic on one 8-bit port: resolves each pin from both drivers.
// Assumes the device drives only where its enable is high.
`timescale 1ns/1ns
module pin_board_model
(
  // Device side of the port.
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // Level the board puts on pins the device leaves alone.
  input  wire logic [7:0] board_val,
  output logic      [7:0] pin_in
);
  // The device wins where it drives, so no pin ever floats unknown.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_val);
endmodule

// >>> verification/test_gpio_ports_ef.sv
// Bench for the GPIO port block: register traffic, pin levels, straps, resets.
// Assumes one board model per port and read data one cycle after the strobe.
`timescale 1ns/1ns
`include "gpio_ef_defines.svh"
module test_gpio_ports_ef
  import gpio_ef_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic        boot_bus_bit_eight = 1'b1, boot_bus_bit_nine = 1'b1, clock_source_select_pin;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, board_e = 8'h00, board_f = 8'h00;
  logic [7:0]  reg_rdata, first_pin_in, first_pin_out, first_pin_oe, d, l, b;
  logic [7:0]  second_pin_in, second_pin_out, second_pin_oe, exp_q[$];
  logic [7:1]  irq_level_n;
  logic [31:0] seed = 32'h0000_5e0e;
  bus_ctrl_t   bus_ctrl = 4'h0;
  bus_ack_t    bus_ack;
  int          err_count = 0, checked = 0, cycles = 0;

  gpio_ports_ef uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .boot_bus_bit_eight, .boot_bus_bit_nine, .first_pin_in, .first_pin_out, .first_pin_oe,
    .second_pin_in, .second_pin_out, .second_pin_oe, .bus_ctrl, .bus_ack, .irq_level_n,
    .clock_source_select_pin);
  pin_board_model board_e_i (.pin_out(first_pin_out), .pin_oe(first_pin_oe),
    .board_val(board_e), .pin_in(first_pin_in));
  pin_board_model board_f_i (.pin_out(second_pin_out), .pin_oe(second_pin_oe),
    .board_val(board_f), .pin_in(second_pin_in));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task report_and_stop;
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobes are never lowered and raised in one step; the caller's next call replaces them.
  task bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] dat);
    // After a mid-cycle check, wait for the next rising edge so inputs move only there.
    if (clk == 1'b0)
      @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] dat);
    bus(1'b1, 1'b0, a, dat);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  task settle;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge clk);
  endtask

  task do_reset(input logic s8, input logic s9, input logic [7:0] bf);
    @(posedge clk);
    rst_n <= 1'b0;
    boot_bus_bit_eight <= s8;
    boot_bus_bit_nine <= s9;
    board_f <= bf;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    board_f <= ~bf;
    settle;
  endtask

  // Clock, hang guard and the read monitor that pairs answers with noted values.
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      report_and_stop;
    end
  end
  always @(posedge clk) rd_d <= reg_rd && rst_n;
  always @(negedge clk) if (rd_d) check(reg_rdata, exp_q.pop_front());

  // Main sequence: dedicated use, random plain I/O, then a second reset.
  initial
  begin
    do_reset(1'b1, 1'b1, 8'h55);
    check({7'h00, clock_source_select_pin}, 8'h01);
    check({irq_level_n, 1'b0}, 8'hAA);
    rd(`OFS_FIRST_FUNC_SELECT, 8'hFF);
    rd(`OFS_SECOND_FUNC_SELECT, 8'hFF);
    rd(`OFS_SECOND_DIRECTION, 8'h00);
    b = rnd();
    board_e <= b;
    bus_ctrl <= b[7:4];
    wr(`OFS_FIRST_DIRECTION, 8'hFF);
    wr(`OFS_FIRST_LATCH_A, 8'h00);
    settle;
    check(first_pin_out & 8'hF0, {b[7:4], 4'h0});
    check(first_pin_oe, 8'hF0);
    check({5'h00, bus_ack}, {5'h00, b[2:0]});
    wr(`OFS_FIRST_FUNC_SELECT, 8'h00);
    wr(`OFS_SECOND_FUNC_SELECT, 8'h00);
    rd(`OFS_FIRST_FUNC_SELECT, 8'h08);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    repeat (16)
    begin
      d = rnd() | 8'h08;
      l = rnd();
      b = rnd();
      wr(`OFS_FIRST_DIRECTION, d);
      board_e <= b;
      board_f <= ~b;
      rd(`OFS_FIRST_DIRECTION, d);
      wr(l[0] ? `OFS_FIRST_LATCH_A : `OFS_FIRST_LATCH_B, l);
      wr(`OFS_SECOND_DIRECTION, ~d);
      wr(l[1] ? `OFS_SECOND_LATCH_B : `OFS_SECOND_LATCH_A, ~l);
      rd(l[0] ? `OFS_FIRST_LATCH_B : `OFS_FIRST_LATCH_A, (d & l) | (~d & b));
      rd(l[1] ? `OFS_SECOND_LATCH_A : `OFS_SECOND_LATCH_B, (~d & ~l) | (d & ~b));
      settle;
      check(first_pin_oe, d & 8'hF7);
      check(first_pin_out & d & 8'hF7, l & d & 8'hF7);
      check(second_pin_oe, ~d);
      check(second_pin_out & ~d, ~l & ~d);
    end
    wr(`OFS_FIRST_FUNC_SELECT, 8'hFF);
    rd(`OFS_FIRST_LATCH_A, l);
    rd(`OFS_FIRST_DIRECTION, d);
    settle;
    do_reset(1'b0, 1'b0, 8'h00);
    check({7'h00, clock_source_select_pin}, 8'h00);
    rd(`OFS_FIRST_FUNC_SELECT, 8'h08);
    rd(`OFS_SECOND_FUNC_SELECT, 8'h00);
    settle;
    @(posedge clk);
    report_and_stop;
  end
endmodule
